/* File: rtl/cpuoag_core.sv */
// operand address generation sequencer for a 20-bit core
`timescale 1ns/1ns
module cpuoag_core
  import cpuoag_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // memory bus
  output logic      [19:0] memAddr,
  output logic             memRead,
  input  wire logic [15:0] memData,
  input  wire logic        memReady,
  // operand results
  output logic      [19:0] srcAddr,
  output logic      [19:0] srcImm,
  output logic             srcIsImm,
  output logic      [19:0] dstAddr,
  output logic             dstIsMem,
  output logic             operandValid,
  output logic      [1:0]  opSize,
  output logic             illegalMode,
  // register file view
  output logic      [19:0] pcValue,
  input  wire logic [3:0]  regSel,
  output logic      [19:0] regValue
);

  typedef enum logic [2:0] {
    ST_FETCH,
    ST_SRCWORD,
    ST_DSTWORD,
    ST_RETWORD,
    ST_DONE
  } cpuoag_state_type;

  cpuoag_state_type state, next_state;
  logic [19:0] regs [REG_N];
  logic [19:0] next_regs [REG_N];
  logic [15:0] insn, next_insn;
  logic [15:0] extWord, next_extWord;
  logic        extValid, next_extValid;
  logic [19:0] next_memAddr;
  logic        next_memRead;
  logic [19:0] next_srcAddr, next_srcImm, next_dstAddr;
  logic        next_srcIsImm, next_dstIsMem, next_operandValid;
  logic [1:0]  next_opSize;
  logic        next_illegalMode;
  logic [19:0] next_regValue;
  logic [15:0] retLow, next_retLow;

  // decode of the latched instruction
  logic [3:0]  sReg, dReg;
  logic [1:0]  asMode;
  logic        adBit, bwBit, isExt, isDouble, cgConst;
  logic [19:0] incAmt;
  cpuoag_size_type size;
  logic [19:0] calcSrc, calcDst;
  logic [19:0] srcBaseReg;

  assign sReg     = insn[SREG_HI:SREG_LO];
  assign dReg     = insn[DREG_HI:DREG_LO];
  assign asMode   = insn[AS_HI:AS_LO];
  assign adBit    = insn[AD_BIT];
  assign bwBit    = insn[BW_BIT];
  assign isExt    = extValid;
  // the 12 base double-operand opcodes
  assign isDouble = insn[OPC_HI:OPC_LO] >= OPC_FIRST2;
  // cg, and sr in the two indirect modes, supply constants without an extra word
  assign cgConst  = (sReg == REG_CG) ||
                    (sReg == REG_SR && asMode[1]);

  always_comb begin
    // address-word when length bit low and byte bit high
    if (isExt && !extWord[EXT_AL_BIT] && bwBit) begin
      size   = SZ_ADDR;
      incAmt = INC_ADDR;
    end else if (bwBit) begin
      size   = SZ_BYTE;
      incAmt = INC_BYTE;
    end else begin
      size   = SZ_WORD;
      incAmt = INC_WORD;
    end
  end

  assign srcBaseReg = regs[sReg];

  // source: symbolic uses pc, absolute no base
  cpuoag_addr_calc u_src (
    .base     (srcBaseReg),
    .lowWord  (memData),
    .extBits  (extWord[EXT_SRC_HI:EXT_SRC_LO]),
    .useBase  (sReg != REG_SR),
    .extended (isExt),
    .addr     (calcSrc)
  );

  // destination base register already updated if shared
  cpuoag_addr_calc u_dst (
    .base     (regs[dReg]),
    .lowWord  (memData),
    .extBits  (extWord[EXT_DST_HI:EXT_DST_LO]),
    .useBase  (dReg != REG_SR),
    .extended (isExt),
    .addr     (calcDst)
  );

  always_comb begin
    next_state        = state;
    next_regs         = regs;
    next_insn         = insn;
    next_extWord      = extWord;
    next_extValid     = extValid;
    next_memAddr      = memAddr;
    next_memRead      = memRead;
    next_srcAddr      = srcAddr;
    next_srcImm       = srcImm;
    next_srcIsImm     = srcIsImm;
    next_dstAddr      = dstAddr;
    next_dstIsMem     = dstIsMem;
    next_operandValid = 1'b0;
    next_opSize       = opSize;
    next_illegalMode  = illegalMode;
    next_retLow       = retLow;
    next_regValue     = regs[regSel];
    unique case (state)
      ST_FETCH: begin
        next_memAddr = regs[REG_PC];
        next_memRead = 1'b1;
        if (memRead && memReady) begin
          next_regs[REG_PC] = regs[REG_PC] + INC_WORD;
          next_memAddr      = regs[REG_PC] + INC_WORD;
          if (memData[EXT_TAG_HI:EXT_TAG_LO] == EXT_TAG && !extValid) begin
            // extension word must precede the extended form
            next_extWord  = memData;
            next_extValid = 1'b1;
          end else begin
            next_insn    = memData;
            next_state   = ST_SRCWORD;
            next_memRead = 1'b0;
          end
        end
      end
      ST_SRCWORD: begin
        next_opSize      = size;
        next_illegalMode = 1'b0;
        // returns first: the short form sits in the mov opcode space
        if ((insn & LRET_MASK) == LRET_CODE || insn == INSN_SRET) begin
          // return pops from stack; short form truncated
          next_memAddr = regs[REG_SP];
          next_memRead = 1'b1;
          next_state   = ST_RETWORD;
        end else if (!isDouble) begin
          next_state = ST_DONE;
        end else begin
          next_srcIsImm    = 1'b0;
          unique case (asMode)
            AS_REG: begin
              if (sReg == REG_CG) next_srcIsImm = 1'b1;
              next_srcAddr = srcBaseReg;
              next_state   = ST_DSTWORD;
            end
            AS_IND: begin
              // register content is the address, not modified
              next_srcAddr  = srcBaseReg;
              next_srcIsImm = cgConst;
              next_state    = ST_DSTWORD;
            end
            AS_INC: begin
              if (cgConst) begin
                next_srcIsImm = 1'b1;
                next_state    = ST_DSTWORD;
              end else if (sReg == REG_PC) begin
                // immediate through pc, always +2
                next_memRead = 1'b1;
                if (memRead && memReady) begin
                  next_regs[REG_PC] = regs[REG_PC] + INC_WORD;
                  next_memAddr      = regs[REG_PC] + INC_WORD;
                  next_srcIsImm     = 1'b1;
                  // base 16-bit, extended 20-bit constant
                  next_srcImm = isExt ?
                    {extWord[EXT_SRC_HI:EXT_SRC_LO], memData} :
                    {4'h0, memData};
                  next_memRead = 1'b0;
                  next_state   = ST_DSTWORD;
                end
              end else begin
                // fetch at old value then step
                next_srcAddr     = srcBaseReg;
                next_regs[sReg]  = srcBaseReg + incAmt;
                next_state       = ST_DSTWORD;
              end
            end
            default: begin
              if (sReg == REG_CG) begin
                next_srcIsImm = 1'b1;
                next_state    = ST_DSTWORD;
              end else begin
                // appended source word
                next_memRead = 1'b1;
                if (memRead && memReady) begin
                  next_regs[REG_PC] = regs[REG_PC] + INC_WORD;
                  next_memAddr      = regs[REG_PC] + INC_WORD;
                  // extended symbolic: pc of index word
                  // base symbolic low 64k, extended full
                  next_srcAddr = (!isExt && sReg == REG_PC) ?
                                 (calcSrc & LOW64K_MASK) : calcSrc;
                  next_memRead = 1'b0;
                  next_state   = ST_DSTWORD;
                end
              end
            end
          endcase
        end
      end
      ST_DSTWORD: begin
        // destination has only register or indexed forms
        next_dstIsMem = adBit;
        if (!adBit) begin
          next_dstAddr = regs[dReg];
          next_state   = ST_DONE;
        end else begin
          next_memRead = 1'b1;
          if (memRead && memReady) begin
            next_regs[REG_PC] = regs[REG_PC] + INC_WORD;
            next_memAddr      = regs[REG_PC] + INC_WORD;
            next_dstAddr = (!isExt && dReg == REG_PC) ?
                           (calcDst & LOW64K_MASK) : calcDst;
            next_memRead = 1'b0;
            next_state   = ST_DONE;
          end
        end
      end
      ST_RETWORD: begin
        if (memRead && memReady) begin
          if (insn == INSN_SRET) begin
            next_regs[REG_PC] = {4'h0, memData};
            next_regs[REG_SP] = regs[REG_SP] + INC_WORD;
            next_memRead      = 1'b0;
            next_state        = ST_DONE;
          end else begin
            next_retLow  = memData;
            next_memAddr = regs[REG_SP] + INC_WORD;
            next_regs[REG_SP] = regs[REG_SP] + INC_WORD;
            next_insn    = INSN_SRET ^ LRET_MASK;
            next_state   = ST_RETWORD;
            if (insn == (INSN_SRET ^ LRET_MASK)) begin
              next_regs[REG_PC] = {memData[3:0], retLow};
              next_memRead      = 1'b0;
              next_state        = ST_DONE;
            end
          end
        end
      end
      ST_DONE: begin
        next_operandValid = 1'b1;
        next_extValid     = 1'b0;
        next_state        = ST_FETCH;
      end
      default: next_state = ST_FETCH;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state        <= ST_FETCH;
      for (int i = 0; i < REG_N; i++) regs[i] <= RST_PC;
      insn         <= 16'h0000;
      extWord      <= 16'h0000;
      extValid     <= 1'b0;
      memAddr      <= RST_PC;
      memRead      <= 1'b0;
      srcAddr      <= 20'h00000;
      srcImm       <= 20'h00000;
      srcIsImm     <= 1'b0;
      dstAddr      <= 20'h00000;
      dstIsMem     <= 1'b0;
      operandValid <= 1'b0;
      opSize       <= 2'h0;
      illegalMode  <= 1'b0;
      retLow       <= 16'h0000;
      regValue     <= 20'h00000;
      pcValue      <= RST_PC;
    end else begin
      state        <= next_state;
      regs         <= next_regs;
      insn         <= next_insn;
      extWord      <= next_extWord;
      extValid     <= next_extValid;
      memAddr      <= next_memAddr;
      memRead      <= next_memRead;
      srcAddr      <= next_srcAddr;
      srcImm       <= next_srcImm;
      srcIsImm     <= next_srcIsImm;
      dstAddr      <= next_dstAddr;
      dstIsMem     <= next_dstIsMem;
      operandValid <= next_operandValid;
      opSize       <= next_opSize;
      illegalMode  <= next_illegalMode;
      retLow       <= next_retLow;
      regValue     <= next_regValue;
      pcValue      <= next_regs[REG_PC];
    end
  end

endmodule

/* File: rtl/cpuoag_pkg.sv */
// constants and types for the operand address generator
package cpuoag_pkg;

  localparam int ADDR_W    = 20;
  localparam int WORD_W    = 16;
  localparam int EXT_W     = 4;
  localparam int REG_N     = 16;
  localparam int REG_SEL_W = 4;

  // register numbers
  localparam logic [3:0] REG_PC = 4'h0;
  localparam logic [3:0] REG_SP = 4'h1;
  localparam logic [3:0] REG_SR = 4'h2;
  localparam logic [3:0] REG_CG = 4'h3;

  // opcode field positions
  localparam int OPC_HI    = 15;
  localparam int OPC_LO    = 12;
  localparam int SREG_HI   = 11;
  localparam int SREG_LO   = 8;
  localparam int AD_BIT    = 7;
  localparam int BW_BIT    = 6;
  localparam int AS_HI     = 5;
  localparam int AS_LO     = 4;
  localparam int DREG_HI   = 3;
  localparam int DREG_LO   = 0;

  // extension word fields
  localparam logic [4:0]  EXT_TAG    = 5'h03;
  localparam int          EXT_TAG_HI = 15;
  localparam int          EXT_TAG_LO = 11;
  localparam int          EXT_SRC_HI = 10;
  localparam int          EXT_SRC_LO = 7;
  localparam int          EXT_AL_BIT = 6;
  localparam int          EXT_DST_HI = 3;
  localparam int          EXT_DST_LO = 0;

  // double operand opcodes span 4 through f: 12 instructions
  localparam logic [3:0] OPC_FIRST2 = 4'h4;
  localparam int         BASE_INSN_N = 27;
  localparam logic [3:0] OPC_MOV    = 4'h4;

  // single operand / return encodings
  localparam logic [15:0] INSN_SRET  = 16'h4130;
  localparam logic [15:0] LRET_MASK  = 16'hf0ff;
  localparam logic [15:0] LRET_CODE  = 16'h0010;

  // increments
  localparam logic [19:0] INC_BYTE = 20'h00001;
  localparam logic [19:0] INC_WORD = 20'h00002;
  localparam logic [19:0] INC_ADDR = 20'h00004;

  localparam logic [19:0] RST_PC = 20'h00000;
  localparam logic [19:0] LOW64K_MASK = 20'h0ffff;

  typedef enum logic [1:0] {
    SZ_BYTE,
    SZ_WORD,
    SZ_ADDR
  } cpuoag_size_type;

  typedef enum logic [1:0] {
    AS_REG,
    AS_IDX,
    AS_IND,
    AS_INC
  } cpuoag_as_type;

endpackage

/* File: rtl/cpuoag_addr_calc.sv */
// combinational operand address former
`timescale 1ns/1ns
module cpuoag_addr_calc
  import cpuoag_pkg::*;
(
  // inputs
  input  wire logic [19:0] base,
  input  wire logic [15:0] lowWord,
  input  wire logic [3:0]  extBits,
  input  wire logic        useBase,
  input  wire logic        extended,
  // result
  output logic      [19:0] addr
);

  logic [19:0] index;

  always_comb begin
    if (extended) begin
      index = {extBits, lowWord};
    end else begin
      index = {{EXT_W{lowWord[WORD_W-1]}}, lowWord};
    end
    if (!useBase) begin
      // absolute: base form stays in low 64k
      addr = extended ? index : {4'h0, lowWord};
    end else begin
      // carry out of bit 19 dropped
      addr = base + index;
    end
  end

endmodule

/* File: verification/cpuoag_core_properties.sv */
// port-level checks for the operand address generator
`timescale 1ns/1ns
module cpuoag_core_checker
  import cpuoag_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // memory bus
  input  wire logic [19:0] memAddr,
  input  wire logic        memRead,
  input  wire logic [15:0] memData,
  input  wire logic        memReady,
  // operand results
  input  wire logic [19:0] srcAddr,
  input  wire logic [19:0] srcImm,
  input  wire logic        srcIsImm,
  input  wire logic [19:0] dstAddr,
  input  wire logic        dstIsMem,
  input  wire logic        operandValid,
  input  wire logic [1:0]  opSize,
  input  wire logic        illegalMode,
  // register file view
  input  wire logic [19:0] pcValue,
  input  wire logic [3:0]  regSel,
  input  wire logic [19:0] regValue
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  chk_read_held: assert property (
    memRead && !memReady |=> memRead && memAddr == $past(memAddr))
    else $error("read request dropped or moved before ready");
  chk_illegal_never: assert property (
    !illegalMode)
    else $error("illegal mode flagged");
  chk_valid_pulse: assert property (
    operandValid |=> !operandValid)
    else $error("operand valid longer than one cycle");
  // a ready fetch at the program counter advances it by two
  chk_pc_step: assert property (
    memRead && memReady && memAddr == pcValue
      |=> pcValue == $past(pcValue) + 20'h00002)
    else $error("program counter did not advance by two");
  chk_size_legal: assert property (
    operandValid |-> opSize != 2'h3)
    else $error("operand size code out of range");
  chk_result_hold: assert property (
    operandValid |-> $stable(srcAddr) && $stable(dstAddr) &&
      $stable(srcImm))
    else $error("operand result changed in its valid cycle");
  chk_fetch_resume: assert property (
    operandValid |-> ##[1:3] memRead)
    else $error("no fetch after operand results");
  chk_first_read: assert property (
    $rose(rstn) |=> memRead)
    else $error("no fetch after reset release");

  cover property (operandValid && srcIsImm);
  cover property (operandValid && opSize == 2'h2);
  cover property (operandValid && dstIsMem);
endmodule

bind cpuoag_core cpuoag_core_checker chk (.clock(clock), .rstn(rstn),
  .memAddr(memAddr), .memRead(memRead), .memData(memData),
  .memReady(memReady), .srcAddr(srcAddr), .srcImm(srcImm),
  .srcIsImm(srcIsImm), .dstAddr(dstAddr), .dstIsMem(dstIsMem),
  .operandValid(operandValid), .opSize(opSize),
  .illegalMode(illegalMode), .pcValue(pcValue), .regSel(regSel),
  .regValue(regValue));

/* File: verification/cpuoag_mem_model.sv */
// word memory answering the core's fetches with random wait states
`timescale 1ns/1ns
module cpuoag_mem_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // fetch bus
  input  wire logic [19:0] memAddr,
  input  wire logic        memRead,
  output logic      [15:0] memData,
  output logic             memReady,
  // wait-state request
  input  wire logic        stall
);
  logic [15:0] store [0:511];

  // register-to-register filler keeps the core busy past the program
  initial begin
    for (int i = 0; i < 512; i++) begin
      store[i] = 16'h4404;
    end
  end

  // data is garbage outside the ready cycle, never a held copy
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      memReady <= 1'b0;
      memData  <= 16'h0000;
    end else if (memRead && !memReady && !stall) begin
      memReady <= 1'b1;
      memData  <= store[memAddr[9:1]];
    end else begin
      memReady <= 1'b0;
      memData  <= ~memData;
    end
  end
endmodule

/* File: verification/tb.sv */
// bench: program builder, expected results and compare
`timescale 1ns/1ns
module tb;
  import cpuoag_pkg::*;
  typedef struct {
    logic [19:0] sa, si, da, pc, r5;
    bit          imm, mem;
    logic [1:0]  z;
    bit   [2:0]  u;
  } cpuoag_exp_type;

  logic           clock = 1'b0;
  logic           rstn = 1'b0;
  logic           stall = 1'b0;
  logic [3:0]     regSel = 4'h5;
  logic [19:0]    memAddr, srcAddr, srcImm, dstAddr, pcValue, regValue;
  logic [15:0]    memData;
  logic           memRead, memReady, srcIsImm, dstIsMem;
  logic           operandValid, illegalMode;
  logic [1:0]     opSize;
  logic [15:0]    prog [$];
  cpuoag_exp_type exq [$];
  cpuoag_exp_type e;
  int             mismatches = 0;
  int             check_count = 0;
  logic [19:0]    r5 = 20'h00000;
  bit             pend = 0;

  always #20 clock = ~clock;

  cpuoag_core dut (.clock(clock), .rstn(rstn), .memAddr(memAddr),
    .memRead(memRead), .memData(memData), .memReady(memReady),
    .srcAddr(srcAddr), .srcImm(srcImm), .srcIsImm(srcIsImm),
    .dstAddr(dstAddr), .dstIsMem(dstIsMem), .operandValid(operandValid),
    .opSize(opSize), .illegalMode(illegalMode), .pcValue(pcValue),
    .regSel(regSel), .regValue(regValue));
  cpuoag_mem_model bus (.clock(clock), .rstn(rstn), .memAddr(memAddr),
    .memRead(memRead), .memData(memData), .memReady(memReady),
    .stall(stall));

  task automatic check(input logic [19:0] got, input logic [19:0] want);
    check_count++;
    if (got !== want) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic [15:0] opw(int o, int s, bit ad, bit bw,
                                      int as, int d);
    return {o[3:0], s[3:0], ad, bw, as[1:0], d[3:0]};
  endfunction

  function automatic logic [15:0] extw(logic [3:0] sh, bit al,
                                       logic [3:0] dh);
    return {5'h03, sh, al, 2'b00, dh};
  endfunction

  function automatic logic [1:0] sz(bit al, bit bw);
    return !al ? 2'h2 : (bw ? 2'h0 : 2'h1);
  endfunction

  // u flags which of source address, constant, destination to compare
  task automatic push(input logic [19:0] sa, si, da, input bit imm, mem,
                      input logic [1:0] z, input bit [2:0] u);
    exq.push_back('{sa, si, da, 20'(2 * prog.size()), r5, imm, mem, z, u});
  endtask

  always @(negedge clock) begin
    stall = ($urandom % 3) == 0;
    if (pend) check(regValue, e.r5);
    pend = 0;
    if (rstn && operandValid === 1'b1 && exq.size() > 0) begin
      e = exq.pop_front();
      pend = 1;
      if (e.u[2]) check(srcAddr, e.sa);
      if (e.u[1]) check(srcImm, e.si);
      if (e.u[0]) check(dstAddr, e.da);
      check(pcValue, e.pc);
      check({18'h0, opSize}, {18'h0, e.z});
      check({18'h0, srcIsImm, dstIsMem}, {18'h0, e.imm, e.mem});
    end
  end

  initial begin
    int          o;
    int          k;
    bit          al;
    bit          bw;
    logic [15:0] w1;
    logic [15:0] w2;
    logic [3:0]  sh;
    logic [3:0]  dh;
    logic [19:0] p;
    logic [19:0] back;
    void'($urandom(37));
    for (o = 4; o < 16; o++) begin
      bw = $urandom;
      w1 = $urandom;
      w2 = $urandom;
      prog.push_back(opw(o, 2, 1, bw, 1, 2));
      prog.push_back(w1);
      prog.push_back(w2);
      push({4'h0, w1}, 0, {4'h0, w2}, 0, 1, sz(1, bw), 5);
    end
    // byte, word and address-word with extension words
    for (k = 0; k < 3; k++) begin
      al = (k != 2);
      bw = (k != 1);
      sh = $urandom;
      dh = $urandom;
      w1 = $urandom;
      w2 = $urandom;
      prog.push_back(extw(sh, al, dh));
      prog.push_back(opw(5, 2, 1, bw, 1, 2));
      prog.push_back(w1);
      prog.push_back(w2);
      push({sh, w1}, 0, {dh, w2}, 0, 1, sz(al, bw), 5);
      prog.push_back(extw(sh, al, dh));
      prog.push_back(opw(6, 0, 1, bw, 3, 2));
      prog.push_back(w1);
      prog.push_back(w2);
      push(0, {sh, w1}, {dh, w2}, 1, 1, sz(al, bw), 3);
    end
    // second pass forces the sum past the top of memory
    for (k = 0; k < 2; k++) begin
      sh = k ? 4'hf : 4'($urandom);
      w1 = k ? 16'hfff0 : 16'($urandom);
      prog.push_back(extw(sh, 1, 0));
      prog.push_back(opw(7, 0, 0, 0, 1, 4));
      p = 20'(2 * prog.size());
      prog.push_back(w1);
      push(p + {sh, w1}, 0, 0, 0, 0, 1, 4);
    end
    bw = $urandom;
    w1 = $urandom;
    w2 = $urandom;
    prog.push_back(opw(8, 0, 1, bw, 3, 2));
    prog.push_back(w1);
    prog.push_back(w2);
    push(0, {4'h0, w1}, {4'h0, w2}, 1, 1, sz(1, bw), 3);
    for (k = 0; k < 4; k++) begin
      prog.push_back(opw(9, 3, 0, 0, k, 4));
      push(0, 0, 0, 1, 0, 1, 0);
    end
    prog.push_back(opw(10, 5, 0, 0, 2, 4));
    push(r5, 0, 0, 0, 0, 1, 4);
    for (k = 0; k < 3; k++) begin
      al = (k != 2);
      bw = (k != 1);
      if (!al) prog.push_back(extw(0, 0, 0));
      prog.push_back(opw(11, 5, 0, bw, 3, 4));
      p = r5;
      r5 = r5 + (k == 0 ? 1 : k == 1 ? 2 : 4);
      push(p, 0, 0, 0, 0, sz(al, bw), 4);
    end
    prog.push_back(opw(12, 5, 1, 0, 3, 5));
    prog.push_back(16'h0000);
    p = r5;
    r5 = r5 + 2;
    push(p, 0, r5, 0, 1, 1, 5);
    prog.push_back(opw(13, 5, 0, 0, 2, 4));
    push(r5, 0, 0, 0, 0, 1, 4);
    // long return pops the first two words (stack starts at zero);
    // a short return planted at its target pops the third word
    prog.push_back(16'h0010);
    back = {prog[1][3:0], prog[0]};
    push(0, 0, 0, 0, 0, 1, 0);
    exq[exq.size()-1].pc = back;
    push(0, 0, 0, 0, 0, 1, 0);
    exq[exq.size()-1].pc = {4'h0, prog[2]};
    // load after the model's own fill has run
    @(negedge clock);
    foreach (prog[i]) bus.store[i] = prog[i];
    // target word index lies well past the end of the program
    bus.store[back[9:1]] = INSN_SRET;
    repeat (9) @(negedge clock);
    rstn = 1'b1;
    for (k = 0; k < 4000 && exq.size() > 0; k++) @(negedge clock);
    if (exq.size() > 0) mismatches++;
    // let the last register check run before the verdict
    repeat (2) @(negedge clock);
    results();
  end
endmodule
